// File: logic/sofs_pkg.sv
// Purpose: types of the switch output select block
// Assumes: nothing
// Notes: constants live in sofs_regs.svh
package sofs_pkg;

	// output mode combinations of the two switch outputs
	typedef enum logic [1:0] {
		SOFS_PULSE_F_PULSE_R,
		SOFS_PULSE_F_LOGIC,
		SOFS_PULSE_FR_LOGIC,
		SOFS_LOGIC_LOGIC
	} sofs_mode_t;

	// per-output function choice
	typedef enum logic [2:0] {
		SOFS_FN_NONE,
		SOFS_FN_DIRECTION,
		SOFS_FN_ALARM,
		SOFS_FN_RANGE2,
		SOFS_FN_BATCH_END
	} sofs_fn_t;

	// alarm sources: general, min, max, empty pipe, aux pipe, bubble, cond, coating, temp
	typedef logic [8:0] sofs_alarm_t;

	// per-output configuration
	typedef struct packed {
		sofs_alarm_t alarmEn;
		logic normallyClosed;
		sofs_fn_t fn;
	} sofs_out_cfg_t;

	// status from the measuring core
	typedef struct packed {
		logic flowReverse;
		logic range2Active;
		logic fillReached;
		sofs_alarm_t alarms;
	} sofs_core_t;

endpackage : sofs_pkg

// File: logic/sofs_regs.svh
// Purpose: register offsets, field positions and reset values of the switch output select block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef SOFS_REGS_SVH
`define SOFS_REGS_SVH

// =====================================================================
// register byte offsets
`define SOFS_OFF_MODE 12'h000
`define SOFS_OFF_OUT1 12'h004
`define SOFS_OFF_OUT2 12'h008
`define SOFS_OFF_STATUS 12'h00c
`define SOFS_OFF_IRQ_STAT 12'h010
`define SOFS_OFF_IRQ_EN 12'h014
`define SOFS_OFF_IRQ_CLR 12'h018

// =====================================================================
// output config word fields: [2:0] function, [3] polarity, [20:12] alarm enables
`define SOFS_FN_LSB 0
`define SOFS_FN_MSB 2
`define SOFS_POL_BIT 3
`define SOFS_ALM_LSB 12
`define SOFS_ALM_MSB 20

// =====================================================================
// reset values: pulse f / pulse r mode, flow direction select, normally open, no alarms
`define SOFS_MODE_RST 2'h0
`define SOFS_FN_RST 3'h1
`define SOFS_POL_RST 1'b0
`define SOFS_ALM_RST 9'h000

`endif

// File: logic/sofs_switch_out.sv
// Purpose: function select, polarity and alarm gating of the two switched outputs
// Assumes: core status bits are asynchronous to clk and are synchronised here
// Notes: outputs are contact levels, 1 = contact closed
//
// Overview of operation
// - each output selects none, direction, alarm, second range or batch end.
// - function select acts only when mode is logic on both outputs.
// - direction function shows forward flow one way, reverse the other.
// - alarm function driven by that output's own alarm enables.
// - range function active while second flow range is selected.
// - batch end function active once fill quantity is reached.
// - after reset each function select holds flow direction.
// - each output has own polarity, normally open by default.
// - nine separately settable alarm enables per output.
// - second output identical to first, independent settings.
// - output mode offers four pulse/logic combinations.
`timescale 1ns/1ps
`include "sofs_regs.svh"

module sofs_switch_out
	import sofs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// measuring core status, asynchronous
	input wire logic flowReverse,
	input wire logic range2Active,
	input wire logic fillReached,
	input wire logic [8:0] alarmIn,
	// switch outputs and interrupt
	output logic firstSwitchOutput,
	output logic secondSwitchOutput,
	output logic irq
);

	// =====================================================================
	// helpers

	// active level of one output under its configuration
	function automatic logic sofs_active(input sofs_out_cfg_t cfg, input sofs_core_t st);
		logic act;
		act = 1'b0;
		unique case (cfg.fn)
			SOFS_FN_NONE: act = 1'b0;
			SOFS_FN_DIRECTION: act = st.flowReverse;
			SOFS_FN_ALARM: act = |(cfg.alarmEn & st.alarms);
			SOFS_FN_RANGE2: act = st.range2Active;
			SOFS_FN_BATCH_END: act = st.fillReached;
			default: act = 1'b0; // illegal code acts as no function
		endcase
		return act;
	endfunction : sofs_active

	// packs a config into its register word
	function automatic logic [31:0] sofs_pack(input sofs_out_cfg_t cfg);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`SOFS_FN_MSB:`SOFS_FN_LSB] = cfg.fn;
		w[`SOFS_POL_BIT] = cfg.normallyClosed;
		w[`SOFS_ALM_MSB:`SOFS_ALM_LSB] = cfg.alarmEn;
		return w;
	endfunction : sofs_pack

	// unpacks a register word, mapping illegal function codes to no function
	function automatic sofs_out_cfg_t sofs_unpack(input logic [31:0] w);
		sofs_out_cfg_t c;
		c.fn = (w[`SOFS_FN_MSB:`SOFS_FN_LSB] > 3'h4) ? SOFS_FN_NONE
			: sofs_fn_t'(w[`SOFS_FN_MSB:`SOFS_FN_LSB]);
		c.normallyClosed = w[`SOFS_POL_BIT];
		c.alarmEn = w[`SOFS_ALM_MSB:`SOFS_ALM_LSB];
		return c;
	endfunction : sofs_unpack

	// =====================================================================
	// input synchronisers

	sofs_core_t coreMeta_reg;
	sofs_core_t core_reg;

	// two flops; only core_reg is read by logic
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			coreMeta_reg <= '0;
			core_reg <= '0;
		end
		else
		begin
			coreMeta_reg <= {flowReverse, range2Active, fillReached, alarmIn};
			core_reg <= coreMeta_reg;
		end
	end

	// =====================================================================
	// apb register file

	sofs_mode_t mode_reg;
	sofs_out_cfg_t cfg1_reg;
	sofs_out_cfg_t cfg2_reg;
	logic [1:0] irqStat_reg;
	logic [1:0] irqEn_reg;
	logic [1:0] irqClr;
	logic apbWrite;
	logic apbRead;

	assign pready = 1'b1; // zero wait state slave
	assign apbWrite = psel && penable && pwrite;
	assign apbRead = psel && penable && !pwrite;

	// unmapped addresses answer with an error
	always_comb
	begin
		unique case (paddr)
			`SOFS_OFF_MODE, `SOFS_OFF_OUT1, `SOFS_OFF_OUT2, `SOFS_OFF_STATUS,
			`SOFS_OFF_IRQ_STAT, `SOFS_OFF_IRQ_EN, `SOFS_OFF_IRQ_CLR: pslverr = 1'b0;
			default: pslverr = psel && penable;
		endcase
	end

	// mode register, resets to pulse/pulse like a factory setup
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			mode_reg <= sofs_mode_t'(`SOFS_MODE_RST);
		else if (apbWrite && paddr == `SOFS_OFF_MODE)
			mode_reg <= sofs_mode_t'(pwdata[1:0]);
	end

	// output configurations; both outputs are kept fully independent
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfg1_reg <= '{alarmEn: `SOFS_ALM_RST, normallyClosed: `SOFS_POL_RST,
				fn: sofs_fn_t'(`SOFS_FN_RST)};
			cfg2_reg <= '{alarmEn: `SOFS_ALM_RST, normallyClosed: `SOFS_POL_RST,
				fn: sofs_fn_t'(`SOFS_FN_RST)};
		end
		else if (apbWrite)
		begin
			if (paddr == `SOFS_OFF_OUT1)
				cfg1_reg <= sofs_unpack(pwdata);
			if (paddr == `SOFS_OFF_OUT2)
				cfg2_reg <= sofs_unpack(pwdata);
		end
	end

	// =====================================================================
	// output function

	logic logicMode;
	logic act1;
	logic act2;
	logic out1_reg;
	logic out2_reg;

	// select ignored unless both outputs are logic; pulse paths live elsewhere
	assign logicMode = (mode_reg == SOFS_LOGIC_LOGIC);
	assign act1 = logicMode && sofs_active(cfg1_reg, core_reg);
	assign act2 = logicMode && sofs_active(cfg2_reg, core_reg);

	// polarity inverts the resting state: closed contact when inactive if nc
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			out1_reg <= 1'b0;
			out2_reg <= 1'b0;
		end
		else
		begin
			out1_reg <= act1 ^ cfg1_reg.normallyClosed;
			out2_reg <= act2 ^ cfg2_reg.normallyClosed;
		end
	end

	// contacts come straight from flops, so the pins never see combinational hazards
	assign firstSwitchOutput = out1_reg;
	assign secondSwitchOutput = out2_reg;

	// =====================================================================
	// interrupts: bit0/bit1 set on each rise of output activity

	logic act1Prev_reg;
	logic act2Prev_reg;
	logic [1:0] irqSet;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			act1Prev_reg <= 1'b0;
			act2Prev_reg <= 1'b0;
		end
		else
		begin
			act1Prev_reg <= act1;
			act2Prev_reg <= act2;
		end
	end

	assign irqSet = {act2 && !act2Prev_reg, act1 && !act1Prev_reg};
	assign irqClr = (apbWrite && paddr == `SOFS_OFF_IRQ_CLR) ? pwdata[1:0] : 2'h0;

	// set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irqStat_reg <= 2'h0;
		else
			irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
	end

	// enable register; masking never touches the sticky status,
	// so a masked event is still there when software polls for it
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irqEn_reg <= 2'h0;
		else if (apbWrite && paddr == `SOFS_OFF_IRQ_EN)
			irqEn_reg <= pwdata[1:0];
	end

	// level request, high while any enabled status bit stands
	assign irq = |(irqStat_reg & irqEn_reg);

	// =====================================================================
	// read data, registered so it comes from flops

	logic [31:0] rdNext;

	always_comb
	begin
		rdNext = 32'h0000_0000;
		unique case (paddr)
			`SOFS_OFF_MODE: rdNext = {30'h0, mode_reg};
			`SOFS_OFF_OUT1: rdNext = sofs_pack(cfg1_reg);
			`SOFS_OFF_OUT2: rdNext = sofs_pack(cfg2_reg);
			// status shows the synchronised flags, the same ones the outputs use
			`SOFS_OFF_STATUS: rdNext = {16'h0, act2, act1, out2_reg, out1_reg,
				core_reg};
			`SOFS_OFF_IRQ_STAT: rdNext = {30'h0, irqStat_reg};
			`SOFS_OFF_IRQ_EN: rdNext = {30'h0, irqEn_reg};
			default: rdNext = 32'h0000_0000;
		endcase
	end

	// captured in setup so data stands during the access phase
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= rdNext;
	end

	// =====================================================================
	// checks
	// every check sleeps while reset is low; some also watch apb decodes and combinational terms

	// outputs rest at their polarity whenever the select is not in force
	chk_pass_gated: assert property (@(posedge clk) disable iff (!arst_n)
		(mode_reg != SOFS_LOGIC_LOGIC) |=> (out1_reg == $past(cfg1_reg.normallyClosed)))
		else $error("output moved outside logic mode");
	chk_two_gated: assert property (@(posedge clk) disable iff (!arst_n)
		(mode_reg != SOFS_LOGIC_LOGIC) |=> (out2_reg == $past(cfg2_reg.normallyClosed)))
		else $error("second output moved outside logic mode");
	chk_none_rest: assert property (@(posedge clk) disable iff (!arst_n)
		(cfg1_reg.fn == SOFS_FN_NONE) |=> (out1_reg == $past(cfg1_reg.normallyClosed)))
		else $error("no function output not at rest");
	chk_two_none: assert property (@(posedge clk) disable iff (!arst_n)
		(cfg2_reg.fn == SOFS_FN_NONE) |=> (out2_reg == $past(cfg2_reg.normallyClosed)))
		else $error("second no function output not at rest");

	// each function follows its synchronised core flag one edge later;
	// normally open cases check the bare flag, the others the inverted one
	chk_dir_follow: assert property (@(posedge clk) disable iff (!arst_n)
		(logicMode && cfg1_reg.fn == SOFS_FN_DIRECTION && !cfg1_reg.normallyClosed)
		|=> (out1_reg == $past(core_reg.flowReverse)))
		else $error("direction not shown");
	chk_two_dir: assert property (@(posedge clk) disable iff (!arst_n)
		(logicMode && cfg2_reg.fn == SOFS_FN_DIRECTION)
		|=> (out2_reg == ($past(core_reg.flowReverse) ^ $past(cfg2_reg.normallyClosed))))
		else $error("second direction not shown");
	chk_alarm_any: assert property (@(posedge clk) disable iff (!arst_n)
		(logicMode && cfg2_reg.fn == SOFS_FN_ALARM)
		|=> (out2_reg == ($past(|(cfg2_reg.alarmEn & core_reg.alarms))
			^ $past(cfg2_reg.normallyClosed))))
		else $error("alarm output wrong");
	chk_range_two: assert property (@(posedge clk) disable iff (!arst_n)
		(logicMode && cfg1_reg.fn == SOFS_FN_RANGE2 && !cfg1_reg.normallyClosed)
		|=> (out1_reg == $past(core_reg.range2Active)))
		else $error("range output wrong");
	chk_two_range: assert property (@(posedge clk) disable iff (!arst_n)
		(logicMode && cfg2_reg.fn == SOFS_FN_RANGE2)
		|=> (out2_reg == ($past(core_reg.range2Active) ^ $past(cfg2_reg.normallyClosed))))
		else $error("second range output wrong");
	chk_batch_end: assert property (@(posedge clk) disable iff (!arst_n)
		(logicMode && cfg2_reg.fn == SOFS_FN_BATCH_END && cfg2_reg.normallyClosed)
		|=> (out2_reg == !$past(core_reg.fillReached)))
		else $error("batch end output wrong");
	chk_one_batch: assert property (@(posedge clk) disable iff (!arst_n)
		(logicMode && cfg1_reg.fn == SOFS_FN_BATCH_END && !cfg1_reg.normallyClosed)
		|=> (out1_reg == $past(core_reg.fillReached)))
		else $error("first batch end output wrong");

	// configuration only moves on a write, and illegal codes never land
	chk_fn_legal: assert property (@(posedge clk) disable iff (!arst_n)
		(cfg1_reg.fn <= SOFS_FN_BATCH_END) && (cfg2_reg.fn <= SOFS_FN_BATCH_END))
		else $error("illegal function code stored");
	chk_mode_hold: assert property (@(posedge clk) disable iff (!arst_n)
		!(apbWrite && paddr == `SOFS_OFF_MODE) |=> $stable(mode_reg))
		else $error("mode changed without a write");
	chk_cfg_hold: assert property (@(posedge clk) disable iff (!arst_n)
		!(apbWrite && paddr == `SOFS_OFF_OUT2) |=> $stable(cfg2_reg))
		else $error("second output settings changed without a write");

	// interrupt status: an event always lands, a clear alone empties the bit
	chk_irq_sticky: assert property (@(posedge clk) disable iff (!arst_n) // event kept
		(irqSet[0]) |=> irqStat_reg[0])
		else $error("interrupt event lost");
	chk_irq_clear: assert property (@(posedge clk) disable iff (!arst_n) // write one clears
		(irqClr[0] && !irqSet[0]) |=> !irqStat_reg[0])
		else $error("interrupt clear ignored");

	// read data in the access phase is what stood at the setup edge,
	// which is why prdata is captured early rather than in the access phase
	chk_read_data: assert property (@(posedge clk) disable iff (!arst_n) // read path
		apbRead |-> (prdata == $past(rdNext)))
		else $error("read data not from setup phase");

endmodule : sofs_switch_out

// File: tb/sofs_plant_model.sv
// Purpose: plant equipment reading the two switch contacts
// Assumes: contact level 1 means closed
// Notes: samples once per clock; a real input card filters longer
`timescale 1ns/1ps

module sofs_plant_model
(
	// clock
	input wire logic clk,
	// contacts
	input wire logic contact1,
	input wire logic contact2,
	// levels as read by the plant
	output logic [1:0] seenLevel
);
	// plain sampling, the plant never drives back into the block
	always_ff @(posedge clk)
	begin
		seenLevel <= {contact2, contact1};
	end
endmodule : sofs_plant_model

// File: tb/testbench.sv
// Purpose: self-checking bench of the switch output select block
// Assumes: pready answers at once, outputs follow core inputs in 3 edges
// Notes: reset first, then table rows, register, interrupt and mid-run reset cases
`timescale 1ns/1ps
`include "sofs_regs.svh"

module testbench
	import sofs_pkg::*;
;
	// =====================================================================
	// one table row: config, core status and expected {out2, out1}
	typedef struct packed {
		logic [1:0] mode;
		logic [31:0] cfg1;
		logic [31:0] cfg2;
		sofs_core_t core;
		logic [1:0] exp;
	} sofs_row_t;

	localparam sofs_row_t ROWS [0:10] = '{
		'{2'h1, 32'h1, 32'h1, 12'h800, 2'h0},
		'{2'h3, 32'h1, 32'h1, 12'h800, 2'h3},
		'{2'h3, 32'h1, 32'h1, 12'h000, 2'h0},
		'{2'h3, 32'h10002, 32'h100002, 12'h010, 2'h1},
		'{2'h3, 32'h10002, 32'h100002, 12'h100, 2'h2},
		'{2'h3, 32'h3, 32'h4, 12'h400, 2'h1},
		'{2'h3, 32'h3, 32'h4, 12'h200, 2'h2},
		'{2'h3, 32'h8, 32'h9, 12'h000, 2'h3},
		'{2'h3, 32'h1ff00a, 32'h0, 12'h001, 2'h0},
		'{2'h2, 32'h9, 32'h1, 12'h800, 2'h1},
		'{2'h3, 32'h4, 32'hb, 12'h200, 2'h3}
	};

	// =====================================================================
	// stimulus and observation
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, errSeen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic out1, out2;
	logic [1:0] plantSeen;
	sofs_core_t core;
	int failCount, nTests;

	sofs_switch_out sofs_switch_out_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flowReverse(core.flowReverse), .range2Active(core.range2Active),
		.fillReached(core.fillReached), .alarmIn(core.alarms),
		.firstSwitchOutput(out1), .secondSwitchOutput(out2), .irq(irq));

	sofs_plant_model sofs_plant_model_inst (.clk(clk), .contact1(out1), .contact2(out2),
		.seenLevel(plantSeen));

	// 50 MHz
	always #10 clk = ~clk;

	// =====================================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			failCount++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; request held until pready is seen high
	task automatic apbXfer(input logic isWrite, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= isWrite;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apbXfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apbXfer(1'b1, a, d);
	endtask : wr

	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		apbXfer(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdChk

	// two sync edges plus the output register, with margin
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle

	task automatic completeRun;
		$display("comparisons %0d mismatches %0d", nTests, failCount);
		if (failCount == 0 && nTests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : completeRun

	// =====================================================================
	// main sequence
	initial
	begin
		{clk, arst_n, psel, penable, pwrite, paddr, pwdata, core} = '0;
		failCount = 0;
		nTests = 0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		check(32'({out2, out1}), 32'h0);
		rdChk(`SOFS_OFF_MODE, 32'h0);
		rdChk(`SOFS_OFF_OUT1, 32'h1);
		rdChk(`SOFS_OFF_OUT2, 32'h1);
		$display("reset test done");
		foreach (ROWS[i])
		begin
			@(posedge clk);
			core <= ROWS[i].core;
			wr(`SOFS_OFF_MODE, {30'h0, ROWS[i].mode});
			wr(`SOFS_OFF_OUT1, ROWS[i].cfg1);
			wr(`SOFS_OFF_OUT2, ROWS[i].cfg2);
			settle();
			check(32'({out2, out1}), 32'(ROWS[i].exp));
			check(32'(plantSeen), 32'(ROWS[i].exp));
			$display("row %0d done", i);
		end
		// field readback, out-of-range select and an unmapped word
		wr(`SOFS_OFF_OUT1, 32'h1ff00c);
		wr(`SOFS_OFF_OUT2, 32'h5);
		rdChk(`SOFS_OFF_OUT1, 32'h1ff00c);
		rdChk(`SOFS_OFF_OUT2, 32'h0);
		rdChk(12'h01c, 32'h0);
		check(32'(errSeen), 32'h1);
		$display("register test done");
		// interrupt: raise, clear, then masked rise
		@(posedge clk);
		core <= '0;
		wr(`SOFS_OFF_OUT1, 32'h1);
		wr(`SOFS_OFF_MODE, 32'h3);
		settle();
		wr(`SOFS_OFF_IRQ_CLR, 32'h3);
		rdChk(`SOFS_OFF_IRQ_STAT, 32'h0);
		wr(`SOFS_OFF_IRQ_EN, 32'h1);
		core <= 12'h800;
		settle();
		check(32'(irq), 32'h1);
		rdChk(`SOFS_OFF_STATUS, 32'h5800);
		wr(`SOFS_OFF_IRQ_CLR, 32'h1);
		#1;
		check(32'(irq), 32'h0);
		wr(`SOFS_OFF_IRQ_EN, 32'h0);
		core <= '0;
		settle();
		core <= 12'h800;
		settle();
		check(32'(irq), 32'h0);
		rdChk(`SOFS_OFF_IRQ_STAT, 32'h1);
		$display("interrupt test done");
		// mid-run reset with output 1 active: every setting returns to default
		check(32'({out2, out1}), 32'h1);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		check(32'({out2, out1}), 32'h0);
		check(32'(irq), 32'h0);
		rdChk(`SOFS_OFF_MODE, 32'h0);
		rdChk(`SOFS_OFF_OUT1, 32'h1);
		rdChk(`SOFS_OFF_OUT2, 32'h1);
		rdChk(`SOFS_OFF_IRQ_STAT, 32'h0);
		$display("mid-run reset test done");
		completeRun();
	end

	// cut a hang short; the run needs well under 1000 cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		failCount++;
		completeRun();
	end
endmodule : testbench
